/* logic/sys_ctrl_pkg.sv */
// Constants shared by the system control configuration block
package sys_ctrl_pkg;
    // ----------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] IDX_RESET_CONTROL = 4'h3;
    localparam logic [3:0] IDX_SLEEP_CONTROL = 4'h4;
    localparam logic [3:0] IDX_CONFIG_CONTROL = 4'h5;
    localparam logic [3:0] IDX_PRIORITY_ONE = 4'h6;
    localparam logic [3:0] IDX_PRIORITY_TWO = 4'h7;
    localparam logic [3:0] IDX_PRIORITY_THREE = 4'h8;

    // ----------------------------------------------------------------
    // Key-protected reset control word
    // ----------------------------------------------------------------
    localparam logic [15:0] WRITE_KEY = 16'h05fa;
    localparam logic [15:0] KEY_STATUS = 16'hfa05;
    localparam int KEY_LSB = 16;
    localparam int BIT_SYSTEM_RESET_REQUEST = 2;
    localparam int BIT_DEBUG_CLEAR_ACTIVE = 1;
    localparam int BIT_DEBUG_LOCAL_RESET = 0;

    // ----------------------------------------------------------------
    // Sleep control fields
    // ----------------------------------------------------------------
    localparam int BIT_WAKE_ON_ANY_PENDING = 4;
    localparam int BIT_DEEP_SLEEP_SELECT = 2;
    localparam int BIT_SLEEP_AFTER_HANDLER = 1;
    localparam logic [31:0] SLEEP_MASK = 32'h0000_0016;

    // ----------------------------------------------------------------
    // Configuration control fields
    // ----------------------------------------------------------------
    localparam int BIT_STACK_EIGHT_BYTE_ALIGN = 9;
    localparam int BIT_IGNORE_BUS_FAULT_HIGH_PRIO = 8;
    localparam int BIT_DIVIDE_ZERO_TRAP = 4;
    localparam int BIT_MISALIGNED_TRAP = 3;
    localparam int BIT_UNPRIVILEGED_TRIGGER_ACCESS = 1;
    localparam int BIT_THREAD_ENTRY_ANY_LEVEL = 0;
    localparam logic [31:0] CONFIG_MASK = 32'h0000_031b;

    // ----------------------------------------------------------------
    // Priority fields: only the top nibble of each priority byte is stored
    // ----------------------------------------------------------------
    localparam int PRIO_W = 4;
    localparam logic [31:0] PRIO_ONE_MASK = 32'h00f0_f0f0;
    localparam logic [31:0] PRIO_TWO_MASK = 32'hf000_0000;
    localparam logic [31:0] PRIO_THREE_MASK = 32'hf0f0_0000;
    localparam int LSB_MEMORY_FAULT = 4;
    localparam int LSB_BUS_FAULT = 12;
    localparam int LSB_USAGE_FAULT = 20;
    localparam int LSB_SUPERVISOR_CALL = 28;
    localparam int LSB_PENDABLE_SERVICE = 20;
    localparam int LSB_SYSTEM_TICK = 28;

    // Reset value of every stored register
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Low-power state of the core, Gray coded along awake-sleep-deep
    typedef enum logic [1:0] {
        AWAKE = 2'b00,
        LIGHT_SLEEP = 2'b01,
        DEEP_SLEEP = 2'b11
    } power_state_type;
endpackage : sys_ctrl_pkg

/* logic/masked_word_reg.sv */
// Byte-writable 32-bit register storing only the bits of a fixed mask
module masked_word_reg #(
    parameter logic [31:0] MASK = 32'hffff_ffff
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic write_en,
    input wire logic [3:0] byte_en,
    input wire logic [31:0] write_data,
    output logic [31:0] value
);
    // ----------------------------------------------------------------
    // One lane per byte
    // ----------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            logic [7:0] byte_reg;
            // Unmasked bits never store, so they read as zero
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    byte_reg <= sys_ctrl_pkg::REG_RESET[8*lane +: 8];
                end else if (clk_en && write_en && byte_en[lane]) begin
                    byte_reg <= write_data[8*lane +: 8] & MASK[8*lane +: 8];
                end
            end
            assign value[8*lane +: 8] = byte_reg;
        end
    endgenerate
endmodule : masked_word_reg

/* logic/system_control_fault_config.sv */
// System control, sleep, fault configuration and handler priority block
// How it works
// [RL1] Keyed write of one to reset request bit pulses the system reset output.
// [RL2] Reset request resets everything but debug; the bit always reads zero.
// [RL3] Both debug bits of the reset control word always read zero.
// [RL4] Software must write zero to both debug bits.
// [RL5] Wake on enabled pending, or on any pending when wake-any is set.
// [RL6] Send-event and external events always wake the sleeping core.
// [RL7] Deep sleep select picks deep sleep at one, ordinary sleep at zero.
// [RL8] Sleep after handler puts core to sleep on return to thread.
// [RL9] Stack align bit selects eight-byte alignment at one, four at zero.
// [RL10] Entry stores the alignment in stacked status bit 9; return restores it.
// [RL11] Ignore-bit lets priority -1/-2 handlers ignore data bus faults, else lock up.
// [RL12] Software sets the ignore bit only with handler in safe memory.
// [RL13] Divide-zero trap set makes divides by zero trap.
// [RL14] Divide-zero trap clear gives quotient zero without a trap.
// [RL15] Misaligned trap set makes unaligned halfword or word access fault.
// [RL16] Unaligned multiple or doubleword accesses always fault.
// [RL17] Unprivileged trigger access bit grants unprivileged trigger writes.
// [RL18] Thread entry only with no other active exception unless any-level set.
// [RL19] Three priority registers hold levels 0 to 15, byte accessible.
// [RL20] Low nibble of each priority byte reads zero and ignores writes.
// [RL21] First priority word holds usage, bus and memory fault priorities.
// [RL22] Second holds supervisor call; third holds system tick and pendable.
// [RL23] Reset control writes without the key value are ignored.
// [RL24] Reserved bits read as zero and drop writes.
module system_control_fault_config (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic system_reset_out,
    input wire logic sleep_request,
    input wire logic return_to_thread,
    input wire logic irq_pending_enabled,
    input wire logic irq_pending_any,
    input wire logic event_pending,
    input wire logic send_event_exec,
    input wire logic external_event,
    output logic core_sleeping,
    output logic core_deep_sleep,
    output logic core_wake,
    input wire logic exception_entry,
    input wire logic exception_return,
    input wire logic stacked_align_in,
    output logic stacked_align_bit,
    output logic active_align_eight,
    input wire logic data_bus_fault,
    input wire logic negative_priority,
    output logic bus_fault_ignored,
    output logic lockup,
    input wire logic divide_exec,
    input wire logic divisor_zero,
    output logic divide_trap,
    output logic quotient_force_zero,
    input wire logic access_unaligned,
    input wire logic access_multi_or_double,
    output logic unaligned_usage_fault,
    input wire logic unpriv_trigger_req,
    output logic trigger_access_granted,
    input wire logic thread_return_req,
    input wire logic no_other_active,
    output logic thread_entry_allowed,
    output logic [3:0] memory_fault_priority,
    output logic [3:0] bus_fault_priority,
    output logic [3:0] usage_fault_priority,
    output logic [3:0] supervisor_call_priority,
    output logic [3:0] pendable_service_priority,
    output logic [3:0] system_tick_priority
);
    // ----------------------------------------------------------------
    // Avalon slave handshake
    // ----------------------------------------------------------------
    logic ack_reg;
    logic request;
    logic write_done;
    logic [31:0] sleep_word;
    logic [31:0] config_word;
    logic [31:0] prio_one_word;
    logic [31:0] prio_two_word;
    logic [31:0] prio_three_word;
    logic [31:0] read_next;
    logic key_ok;
    sys_ctrl_pkg::power_state_type power_reg;
    sys_ctrl_pkg::power_state_type power_next;

    // Word select used by the write path and the reset request; the read mux decodes the address itself
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] idx);
        hit = (addr == idx);
    endfunction : hit

    assign request = avs_read | avs_write;
    // Every access takes two cycles; a frozen clock enable keeps it waiting
    assign avs_waitrequest = request & ~(ack_reg & clk_en);
    assign write_done = avs_write & ack_reg & clk_en;

    // Acknowledge rises one cycle after the request and drops after use
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= request & ~ack_reg;
        end
    end

    // ----------------------------------------------------------------
    // Stored registers
    // ----------------------------------------------------------------
    // [RL7] sleep fields stored
    masked_word_reg #(.MASK(sys_ctrl_pkg::SLEEP_MASK)) u_sleep (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .write_en(write_done && hit(avs_address, sys_ctrl_pkg::IDX_SLEEP_CONTROL)),
        .byte_en(avs_byteenable),
        .write_data(avs_writedata),
        .value(sleep_word)
    );

    // [RL24] reserved bits dropped
    masked_word_reg #(.MASK(sys_ctrl_pkg::CONFIG_MASK)) u_config (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .write_en(write_done && hit(avs_address, sys_ctrl_pkg::IDX_CONFIG_CONTROL)),
        .byte_en(avs_byteenable),
        .write_data(avs_writedata),
        .value(config_word)
    );

    // [RL20] low nibbles masked
    masked_word_reg #(.MASK(sys_ctrl_pkg::PRIO_ONE_MASK)) u_prio_one (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .write_en(write_done && hit(avs_address, sys_ctrl_pkg::IDX_PRIORITY_ONE)),
        .byte_en(avs_byteenable),
        .write_data(avs_writedata),
        .value(prio_one_word)
    );

    // [RL19] byte-wide priority access
    masked_word_reg #(.MASK(sys_ctrl_pkg::PRIO_TWO_MASK)) u_prio_two (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .write_en(write_done && hit(avs_address, sys_ctrl_pkg::IDX_PRIORITY_TWO)),
        .byte_en(avs_byteenable),
        .write_data(avs_writedata),
        .value(prio_two_word)
    );

    masked_word_reg #(.MASK(sys_ctrl_pkg::PRIO_THREE_MASK)) u_prio_three (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .write_en(write_done && hit(avs_address, sys_ctrl_pkg::IDX_PRIORITY_THREE)),
        .byte_en(avs_byteenable),
        .write_data(avs_writedata),
        .value(prio_three_word)
    );

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Unmapped words read zero; reads have no side effects
    always_comb begin
        read_next = 32'h0000_0000;
        unique case (avs_address)
            // [RL2] reset request reads zero
            // [RL3] debug bits read zero
            sys_ctrl_pkg::IDX_RESET_CONTROL: read_next = {sys_ctrl_pkg::KEY_STATUS, 16'h0000};
            sys_ctrl_pkg::IDX_SLEEP_CONTROL: read_next = sleep_word;
            sys_ctrl_pkg::IDX_CONFIG_CONTROL: read_next = config_word;
            sys_ctrl_pkg::IDX_PRIORITY_ONE: read_next = prio_one_word;
            sys_ctrl_pkg::IDX_PRIORITY_TWO: read_next = prio_two_word;
            sys_ctrl_pkg::IDX_PRIORITY_THREE: read_next = prio_three_word;
            default: read_next = 32'h0000_0000;
        endcase
    end

    // Read data captured on the first cycle of the access
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && avs_read && !ack_reg) begin
            avs_readdata <= read_next;
        end
    end

    // ----------------------------------------------------------------
    // Key-protected system reset request
    // ----------------------------------------------------------------
    // [RL23] key must match
    assign key_ok = avs_byteenable[3] & avs_byteenable[2] & avs_byteenable[0]
        & (avs_writedata[sys_ctrl_pkg::KEY_LSB +: 16] == sys_ctrl_pkg::WRITE_KEY);

    // Debug bits are not acted upon; software is expected to write them zero
    // [RL1] reset request pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            system_reset_out <= 1'b0;
        end else if (clk_en) begin
            system_reset_out <= write_done & key_ok
                & hit(avs_address, sys_ctrl_pkg::IDX_RESET_CONTROL)
                & avs_writedata[sys_ctrl_pkg::BIT_SYSTEM_RESET_REQUEST];
        end
    end

    // ----------------------------------------------------------------
    // Low-power state machine
    // ----------------------------------------------------------------
    logic wake_cause;
    logic sleep_cause;

    // [RL5] wake source selection
    // [RL6] events always wake
    assign wake_cause = irq_pending_enabled | event_pending | send_event_exec | external_event
        | (sleep_word[sys_ctrl_pkg::BIT_WAKE_ON_ANY_PENDING] & irq_pending_any);
    // [RL8] sleep on handler exit
    assign sleep_cause = sleep_request
        | (return_to_thread & sleep_word[sys_ctrl_pkg::BIT_SLEEP_AFTER_HANDLER]);

    // Next low-power state
    always_comb begin
        power_next = power_reg;
        unique case (power_reg)
            sys_ctrl_pkg::AWAKE: begin
                // [RL7] mode chosen at entry
                if (sleep_cause) begin
                    power_next = sleep_word[sys_ctrl_pkg::BIT_DEEP_SLEEP_SELECT]
                        ? sys_ctrl_pkg::DEEP_SLEEP : sys_ctrl_pkg::LIGHT_SLEEP;
                end
            end
            sys_ctrl_pkg::LIGHT_SLEEP,
            sys_ctrl_pkg::DEEP_SLEEP: begin
                if (wake_cause) begin
                    power_next = sys_ctrl_pkg::AWAKE;
                end
            end
            default: power_next = sys_ctrl_pkg::AWAKE;
        endcase
    end

    // State register and wake pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_reg <= sys_ctrl_pkg::AWAKE;
            core_wake <= 1'b0;
        end else if (clk_en) begin
            power_reg <= power_next;
            core_wake <= (power_reg != sys_ctrl_pkg::AWAKE) & wake_cause;
        end
    end

    assign core_sleeping = (power_reg != sys_ctrl_pkg::AWAKE);
    assign core_deep_sleep = (power_reg == sys_ctrl_pkg::DEEP_SLEEP);

    // ----------------------------------------------------------------
    // Stack alignment on exception entry and return
    // ----------------------------------------------------------------
    // [RL9] alignment select
    // [RL10] record and restore
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stacked_align_bit <= 1'b0;
            active_align_eight <= 1'b0;
        end else if (clk_en) begin
            if (exception_entry) begin
                stacked_align_bit <= config_word[sys_ctrl_pkg::BIT_STACK_EIGHT_BYTE_ALIGN];
                active_align_eight <= config_word[sys_ctrl_pkg::BIT_STACK_EIGHT_BYTE_ALIGN];
            end else if (exception_return) begin
                active_align_eight <= stacked_align_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault and trap decisions
    // ----------------------------------------------------------------
    // Lock-up is sticky: only a reset leaves it
    // [RL11] ignore or lock up
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_fault_ignored <= 1'b0;
            lockup <= 1'b0;
        end else if (clk_en) begin
            bus_fault_ignored <= data_bus_fault & negative_priority
                & config_word[sys_ctrl_pkg::BIT_IGNORE_BUS_FAULT_HIGH_PRIO];
            if (data_bus_fault && negative_priority
                && !config_word[sys_ctrl_pkg::BIT_IGNORE_BUS_FAULT_HIGH_PRIO]) begin
                lockup <= 1'b1;
            end
        end
    end

    // [RL13] divide trap
    // [RL14] zero quotient
    // [RL15] misaligned trap
    // [RL16] multiples always fault
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            divide_trap <= 1'b0;
            quotient_force_zero <= 1'b0;
            unaligned_usage_fault <= 1'b0;
        end else if (clk_en) begin
            divide_trap <= divide_exec & divisor_zero & config_word[sys_ctrl_pkg::BIT_DIVIDE_ZERO_TRAP];
            quotient_force_zero <= divide_exec & divisor_zero
                & ~config_word[sys_ctrl_pkg::BIT_DIVIDE_ZERO_TRAP];
            unaligned_usage_fault <= access_unaligned
                & (access_multi_or_double | config_word[sys_ctrl_pkg::BIT_MISALIGNED_TRAP]);
        end
    end

    // Access grants are handshake answers, so they stay combinational
    // [RL17] trigger access
    assign trigger_access_granted = unpriv_trigger_req
        & config_word[sys_ctrl_pkg::BIT_UNPRIVILEGED_TRIGGER_ACCESS];
    // [RL18] thread entry check
    assign thread_entry_allowed = thread_return_req
        & (no_other_active | config_word[sys_ctrl_pkg::BIT_THREAD_ENTRY_ANY_LEVEL]);

    // ----------------------------------------------------------------
    // Priority fields to the exception logic
    // ----------------------------------------------------------------
    // [RL21] first word layout
    assign memory_fault_priority = prio_one_word[sys_ctrl_pkg::LSB_MEMORY_FAULT +: sys_ctrl_pkg::PRIO_W];
    assign bus_fault_priority = prio_one_word[sys_ctrl_pkg::LSB_BUS_FAULT +: sys_ctrl_pkg::PRIO_W];
    assign usage_fault_priority = prio_one_word[sys_ctrl_pkg::LSB_USAGE_FAULT +: sys_ctrl_pkg::PRIO_W];
    // [RL22] second and third layout
    assign supervisor_call_priority = prio_two_word[sys_ctrl_pkg::LSB_SUPERVISOR_CALL +: sys_ctrl_pkg::PRIO_W];
    assign pendable_service_priority =
        prio_three_word[sys_ctrl_pkg::LSB_PENDABLE_SERVICE +: sys_ctrl_pkg::PRIO_W];
    assign system_tick_priority = prio_three_word[sys_ctrl_pkg::LSB_SYSTEM_TICK +: sys_ctrl_pkg::PRIO_W];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence keyed_reset_write;
        write_done && key_ok && avs_address == sys_ctrl_pkg::IDX_RESET_CONTROL
            && avs_writedata[sys_ctrl_pkg::BIT_SYSTEM_RESET_REQUEST];
    endsequence

    sequence wake_seen;
        clk_en && core_sleeping && wake_cause;
    endsequence

    // [RL1] keyed write pulses reset
    a_reset_pulse_sent: assert property (keyed_reset_write |=> system_reset_out)
        else $error("keyed reset write gave no reset pulse");
    // [RL23] unkeyed write ignored
    a_unkeyed_write_ignored: assert property (system_reset_out && $past(clk_en) |-> $past(write_done && key_ok))
        else $error("reset pulse without keyed write");
    // [RL2] request bit reads zero
    a_reset_bit_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == sys_ctrl_pkg::IDX_RESET_CONTROL
        |-> avs_readdata[2:0] == 3'h0)
        else $error("reset control low bits read nonzero");
    // [RL6] wake ends sleep
    a_sleep_wakes_up: assert property (wake_seen |=> !core_sleeping && core_wake)
        else $error("core stayed asleep after wake cause");
    // [RL7] deep select honoured
    a_deep_sleep_mode: assert property (
        clk_en && !core_sleeping && sleep_cause
        |=> core_deep_sleep == $past(sleep_word[sys_ctrl_pkg::BIT_DEEP_SLEEP_SELECT]))
        else $error("wrong low-power mode entered");
    // [RL5] disabled irq ignored
    a_disabled_irq_no_wake: assert property (
        clk_en && core_sleeping && !wake_cause ##1 clk_en |-> core_sleeping)
        else $error("core woke without cause");
    // [RL14] zero quotient path
    a_divide_outcome: assert property (
        clk_en && divide_exec && divisor_zero |=> divide_trap != quotient_force_zero)
        else $error("divide by zero neither trapped nor zeroed");
    // [RL16] multiples always fault
    a_multiple_faults: assert property (
        clk_en && access_unaligned && access_multi_or_double |=> unaligned_usage_fault)
        else $error("unaligned multiple access did not fault");
    // [RL11] lockup stays
    a_lockup_sticky: assert property (lockup |=> lockup)
        else $error("lock-up released without reset");
    // [RL10] return restores alignment
    a_align_restore: assert property (
        clk_en && exception_return && !exception_entry |=> active_align_eight == $past(stacked_align_in))
        else $error("alignment not restored on return");
    // [RL20] low nibble clear
    a_prio_nibble_zero: assert property (((prio_one_word | prio_two_word | prio_three_word) & 32'h0f0f_0f0f) == 32'h0)
        else $error("priority low nibble stored");
endmodule : system_control_fault_config

/* sim/reset_ctrl_model.sv */
// Behavioural system reset controller standing beyond the block's reset output
module reset_ctrl_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic system_reset_out,
    output int reset_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count reset requests; debug logic is not ours to reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_count <= 0;
        end else if (system_reset_out === 1'b1) begin
            reset_count <= reset_count + 1;
        end
    end
endmodule : reset_ctrl_model

/* sim/system_control_fault_config_test.sv */
// Self-checking bench for the system control configuration block
module system_control_fault_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [7:0] ev = 8'h0;
    logic sleep_request = 1'b0, irq_pending_any = 1'b0, external_event = 1'b0, system_reset_out, lockup;
    logic return_to_thread = 1'b0, irq_pending_enabled = 1'b0, event_pending = 1'b0, send_event_exec = 1'b0;
    logic exception_return = 1'b0, stacked_align_in = 1'b1, access_multi_or_double = 1'b0, no_other_active = 1'b0;
    wire logic divide_exec = ev[7], divisor_zero = ev[6], access_unaligned = ev[5], exception_entry = ev[4];
    wire logic data_bus_fault = ev[3], negative_priority = ev[2], unpriv_trigger_req = ev[1];
    wire logic thread_return_req = ev[0];
    logic core_sleeping, core_deep_sleep, core_wake, stacked_align_bit, active_align_eight, bus_fault_ignored;
    logic divide_trap, quotient_force_zero, unaligned_usage_fault, trigger_access_granted, thread_entry_allowed;
    logic [3:0] memory_fault_priority, bus_fault_priority, usage_fault_priority, supervisor_call_priority;
    logic [3:0] pendable_service_priority, system_tick_priority;
    int error_cnt = 0, check_count = 0, cycles = 0, reset_count;
    system_control_fault_config i_dut (.*);
    reset_ctrl_model i_rst (.ref_clk(ref_clk), .arst_n(arst_n), .system_reset_out(system_reset_out),
        .reset_count(reset_count));
    initial forever #2 ref_clk = ~ref_clk;
    // Watchdog: the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, s, e);
        end
    endtask : chk
    // Avalon access held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task t_regs;
        logic [31:0] m [5];
        logic [3:0] a;
        m = '{sys_ctrl_pkg::SLEEP_MASK, sys_ctrl_pkg::CONFIG_MASK, sys_ctrl_pkg::PRIO_ONE_MASK,
              sys_ctrl_pkg::PRIO_TWO_MASK, sys_ctrl_pkg::PRIO_THREE_MASK};
        for (int i = 0; i < 5; i++) begin
            a = sys_ctrl_pkg::IDX_SLEEP_CONTROL + 4'(i);
            bus(1'b0, a, 32'h0, 4'hf);
            chk(q, sys_ctrl_pkg::REG_RESET);
            bus(1'b1, a, 32'hffff_ffff, 4'hf);
            bus(1'b0, a, 32'h0, 4'hf);
            chk(q, m[i]);
        end
        bus(1'b1, sys_ctrl_pkg::IDX_PRIORITY_ONE, 32'h0, 4'b0010);
        bus(1'b0, sys_ctrl_pkg::IDX_PRIORITY_ONE, 32'h0, 4'hf);
        chk(q, 32'h00f0_00f0);
        chk({bus_fault_priority, usage_fault_priority, memory_fault_priority}, 12'h0ff);
        chk({supervisor_call_priority, pendable_service_priority, system_tick_priority}, 12'hfff);
        bus(1'b1, 4'hf, 32'hffff_ffff, 4'hf);
        bus(1'b0, 4'hf, 32'h0, 4'hf);
        chk(q, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task t_reset;
        bus(1'b1, sys_ctrl_pkg::IDX_RESET_CONTROL, 32'h1234_0004, 4'hf);
        bus(1'b1, sys_ctrl_pkg::IDX_RESET_CONTROL, {sys_ctrl_pkg::WRITE_KEY, 16'h0004}, 4'hf);
        repeat (2) @(posedge ref_clk);
        chk(reset_count, 1);
        bus(1'b0, sys_ctrl_pkg::IDX_RESET_CONTROL, 32'h0, 4'hf);
        chk(q, {sys_ctrl_pkg::KEY_STATUS, 16'h0});
        $display("t_reset done");
    endtask : t_reset
    // Each configuration bit both ways; lock-up is sticky so its set case runs last
    task t_core;
        logic [31:0] c;
        for (int k = 0; k < 2; k++) begin
            c = k ? 32'h0 : sys_ctrl_pkg::CONFIG_MASK;
            bus(1'b1, sys_ctrl_pkg::IDX_CONFIG_CONTROL, c, 4'hf);
            @(posedge ref_clk);
            ev <= 8'hff;
            #1;
            chk({trigger_access_granted, thread_entry_allowed}, {c[1], c[0]});
            @(posedge ref_clk);
            ev <= 8'h0;
            exception_return <= 1'(k);
            #1;
            chk({divide_trap, quotient_force_zero, unaligned_usage_fault, active_align_eight, bus_fault_ignored,
                lockup, stacked_align_bit},
                {c[4], !c[4], c[3], c[9], c[8], !c[8], c[9]});
        end
        @(posedge ref_clk);
        #1;
        chk(active_align_eight, 1'b1);
        $display("t_core done");
    endtask : t_core
    task t_sleep;
        bus(1'b1, sys_ctrl_pkg::IDX_SLEEP_CONTROL, 32'h0000_0004, 4'hf);
        @(posedge ref_clk);
        sleep_request <= 1'b1;
        @(posedge ref_clk);
        sleep_request <= 1'b0;
        irq_pending_any <= 1'b1;
        repeat (3) @(posedge ref_clk);
        external_event <= 1'b1;
        #1;
        chk({core_sleeping, core_deep_sleep}, 2'b11);
        @(posedge ref_clk);
        external_event <= 1'b0;
        irq_pending_any <= 1'b0;
        #1;
        chk({core_sleeping, core_wake}, 2'b01);
        $display("t_sleep done");
    endtask : t_sleep
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs();
        t_reset();
        t_core();
        t_sleep();
        report_and_stop();
    end
endmodule : system_control_fault_config_test
